//--- hdl/vic_regs.svh
// Register offsets, field positions, reset values and fixed numbers
// of the vectored interrupt controller. Definitions only.
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// Register byte offsets on the plain register port
`define VIC_OFS_CONFIG     8'h00
`define VIC_OFS_SYSTEM_REQUEST_BIT     8'h04
`define VIC_OFS_ENABLE     8'h08
`define VIC_OFS_IRQ_PRI    8'h0C
`define VIC_OFS_SYS_PRI    8'h10
`define VIC_OFS_PENDING    8'h14
`define VIC_OFS_SOFT       8'h18
`define VIC_OFS_ACTIVE     8'h1C
`define VIC_OFS_VECTOR     8'h20

// Field positions
`define VIC_CFG_RAM_BIT    0
`define VIC_SYSTEM_REQUEST_BIT_BIT     0
`define VIC_NO_OVR_BIT     1
`define VIC_SYS_SVC_LSB    0
`define VIC_SYS_PENDING_SERVICE_EXCEPTION_LSB 2
`define VIC_SYS_TICK_LSB   4
`define VIC_SOFT_PSV_SET   0
`define VIC_SOFT_PSV_CLR   1
`define VIC_SOFT_TICK_SET  2
`define VIC_SOFT_TICK_CLR  3
`define VIC_SOFT_NMI_SET   4

// Reset values
`define VIC_RST_ENABLE     16'h0000
`define VIC_RST_IRQ_PRI    32'h0000_0000
`define VIC_RST_SYS_PRI    6'h00
`define VIC_RST_EXC        32'h0000_0000

// Exception numbers
`define VIC_EXC_NONE       5'h00
`define VIC_EXC_RESET      5'h01
`define VIC_EXC_NMI        5'h02
`define VIC_EXC_HARD       5'h03
`define VIC_EXC_SVC        5'h0B
`define VIC_EXC_PENDING_SERVICE_EXCEPTION     5'h0E
`define VIC_EXC_TICK       5'h0F
`define VIC_EXC_IRQ0       5'h10
`define VIC_NUM_IRQ        16

// Effective priority codes, lower wins
`define VIC_EFF_NMI        3'h0
`define VIC_EFF_HARD       3'h1
`define VIC_EFF_CFG_BASE   3'h2
`define VIC_EFF_NONE       3'h7

// Table bases and boot redirect addresses
`define VIC_BASE_FLASH     32'h0000_0000
`define VIC_BASE_RAM       32'h2000_0000
`define VIC_ADDR_SP        32'h0000_0000
`define VIC_ADDR_RESET     32'h0000_0004
`define VIC_ADDR_NMI       32'h0000_0008

`endif

//--- hdl/vic_pkg.sv
// Types shared by the vectored interrupt controller.
// Assumes vic_regs.svh supplies the numeric constants.
package vic_pkg;
   typedef enum logic [1:0] {
      BOOT_SP  = 2'b00,
      BOOT_RST = 2'b01,
      RUN      = 2'b11
   } boot_state_t;
   typedef logic [2:0] eff_pri_t;
   typedef logic [4:0] exc_num_t;
endpackage : vic_pkg

//--- hdl/vectored_interrupt_controller.sv
// Vectored interrupt controller: pending latch, priority resolution,
// nesting bookkeeping, vector address and boot-ROM read redirect.
// Assumes one 200 MHz clock, core handshake pulses on the same clock,
// and peripheral request lines from outside this clock's domain.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`include "vic_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_controller (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [31:0] o_reg_rdata,
   // Peripheral request lines
   input  wire logic [15:0] i_irq,
   // Core exception sources
   input  wire logic        i_nmi_req,
   input  wire logic        i_hard_fault,
   input  wire logic        i_svc_req,
   input  wire logic        i_tick_req,
   // Core handshake
   input  wire logic        i_boot_ack,
   input  wire logic        i_exc_entry,
   input  wire logic [4:0]  i_entry_num,
   input  wire logic        i_exc_return,
   output logic             o_irq_req,
   output logic      [4:0]  o_exc_num,
   output logic      [31:0] o_vector_addr,
   output logic             o_sp_load,
   output logic             o_booting,
   // Memory read redirect
   input  wire logic        i_mem_rd,
   input  wire logic [31:0] i_mem_addr,
   output logic             o_mem_rd,
   output logic             o_mem_rom_sel,
   output logic      [31:0] o_mem_addr
);

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Effective priority code of one exception number
   function automatic vic_pkg::eff_pri_t eff_pri(
      input vic_pkg::exc_num_t num,
      input logic [31:0]       irq_pri,
      input logic [5:0]        sys_pri
   );
      logic [1:0] p;
      p = 2'h0;
      eff_pri = `VIC_EFF_NONE;
      if (num == `VIC_EXC_NMI) begin
         eff_pri = `VIC_EFF_NMI;
      end else if (num == `VIC_EXC_HARD) begin
         eff_pri = `VIC_EFF_HARD;
      end else if (num == `VIC_EXC_SVC) begin
         p = sys_pri[`VIC_SYS_SVC_LSB +: 2];
         eff_pri = `VIC_EFF_CFG_BASE + {1'b0, p};
      end else if (num == `VIC_EXC_PENDING_SERVICE_EXCEPTION) begin
         p = sys_pri[`VIC_SYS_PENDING_SERVICE_EXCEPTION_LSB +: 2];
         eff_pri = `VIC_EFF_CFG_BASE + {1'b0, p};
      end else if (num == `VIC_EXC_TICK) begin
         p = sys_pri[`VIC_SYS_TICK_LSB +: 2];
         eff_pri = `VIC_EFF_CFG_BASE + {1'b0, p};
      end else if (num >= `VIC_EXC_IRQ0) begin
         p = irq_pri[{num[3:0], 1'b0} +: 2];
         eff_pri = `VIC_EFF_CFG_BASE + {1'b0, p};
      end
   endfunction : eff_pri

   // Boot-ROM redirect decision for a flash read address
   function automatic logic rom_redirect(
      input logic [31:0] addr,
      input logic        no_ovr,
      input logic        system_request_bit
   );
      rom_redirect = ((addr == `VIC_ADDR_SP || addr == `VIC_ADDR_RESET) && !no_ovr)
                  || (addr == `VIC_ADDR_NMI && system_request_bit);
   endfunction : rom_redirect

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [1:0]          irq_meta_ff [`VIC_NUM_IRQ];
   logic [15:0]         irq_sync;
   logic [15:0]         irq_prev_ff;
   logic [15:0]         irq_rise;
   logic                table_in_ram_select_ff;
   logic                system_request_bit_ff;
   logic                reset_override_disable_ff;
   logic [15:0]         enable_ff;
   logic [31:0]         irq_pri_ff;
   logic [5:0]          sys_pri_ff;
   logic [31:0]         pend_ff;
   logic [31:0]         nxt_pend;
   logic [31:0]         active_ff;
   logic [31:0]         nxt_active;
   logic [31:0]         pend_set;
   logic [31:0]         pend_clr;
   logic [31:0]         ret_mask;
   logic [31:0]         candidates;
   vic_pkg::boot_state_t state_ff;
   vic_pkg::boot_state_t nxt_state;
   vic_pkg::exc_num_t   win_num;
   vic_pkg::eff_pri_t   win_pri;
   vic_pkg::exc_num_t   inner_num;
   vic_pkg::eff_pri_t   run_pri;
   logic                inner_any;
   logic                req_now;
   logic [31:0]         base_addr;
   logic                wr_soft;
   logic                system_request_bit_rise;
   logic [31:0]         rd_value;
   logic [31:0]         entry_onehot;

   ////////////////////////////////////////////////////////////////////
   // Request line synchronisers and edge detect

   genvar gi;
   generate
      for (gi = 0; gi < `VIC_NUM_IRQ; gi++) begin : g_sync
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               irq_meta_ff[gi] <= 2'h0;
            end else begin
               irq_meta_ff[gi] <= {irq_meta_ff[gi][0], i_irq[gi]};
            end
         end
         assign irq_sync[gi] = irq_meta_ff[gi][1];
      end
   endgenerate

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_prev_ff <= 16'h0000;
      end else begin
         irq_prev_ff <= irq_sync;
      end
   end

   // Edge only, so level and pulse sources look the same here
   assign irq_rise = irq_sync & ~irq_prev_ff;

   ////////////////////////////////////////////////////////////////////
   // Register writes

   assign wr_soft     = i_reg_wr && (i_reg_addr == `VIC_OFS_SOFT);
   assign system_request_bit_rise = i_reg_wr && (i_reg_addr == `VIC_OFS_SYSTEM_REQUEST_BIT)
                        && i_reg_wdata[`VIC_SYSTEM_REQUEST_BIT_BIT] && !system_request_bit_ff;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         table_in_ram_select_ff <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == `VIC_OFS_CONFIG) begin
         table_in_ram_select_ff <= i_reg_wdata[`VIC_CFG_RAM_BIT];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         system_request_bit_ff     <= 1'b0;
         reset_override_disable_ff <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == `VIC_OFS_SYSTEM_REQUEST_BIT) begin
         system_request_bit_ff     <= i_reg_wdata[`VIC_SYSTEM_REQUEST_BIT_BIT];
         reset_override_disable_ff <= i_reg_wdata[`VIC_NO_OVR_BIT];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         enable_ff <= `VIC_RST_ENABLE;
      end else if (i_reg_wr && i_reg_addr == `VIC_OFS_ENABLE) begin
         enable_ff <= i_reg_wdata[15:0];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_pri_ff <= `VIC_RST_IRQ_PRI;
         sys_pri_ff <= `VIC_RST_SYS_PRI;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `VIC_OFS_IRQ_PRI) begin
            irq_pri_ff <= i_reg_wdata;
         end
         if (i_reg_addr == `VIC_OFS_SYS_PRI) begin
            sys_pri_ff <= i_reg_wdata[5:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pending and active bookkeeping

   assign entry_onehot = i_exc_entry ? (32'h0000_0001 << i_entry_num) : 32'h0000_0000;
   assign ret_mask     = (i_exc_return && inner_any)
                         ? (32'h0000_0001 << inner_num) : 32'h0000_0000;

   always_comb begin
      pend_set = 32'h0000_0000;
      pend_clr = entry_onehot;
      // Lines map in order to numbers 16..31
      pend_set[31:16] = irq_rise;
      // Line still high when its handler ends re-pends
      pend_set[31:16] = pend_set[31:16] | (ret_mask[31:16] & irq_sync);
      pend_set[`VIC_EXC_NMI]    = i_nmi_req || system_request_bit_rise
                                  || (wr_soft && i_reg_wdata[`VIC_SOFT_NMI_SET]);
      pend_set[`VIC_EXC_HARD]   = i_hard_fault;
      pend_set[`VIC_EXC_SVC]    = i_svc_req;
      pend_set[`VIC_EXC_PENDING_SERVICE_EXCEPTION] = wr_soft && i_reg_wdata[`VIC_SOFT_PSV_SET];
      pend_set[`VIC_EXC_TICK]   = i_tick_req || (wr_soft && i_reg_wdata[`VIC_SOFT_TICK_SET]);
      if (wr_soft && i_reg_wdata[`VIC_SOFT_PSV_CLR]) begin
         pend_clr[`VIC_EXC_PENDING_SERVICE_EXCEPTION] = 1'b1;
      end
      if (wr_soft && i_reg_wdata[`VIC_SOFT_TICK_CLR]) begin
         pend_clr[`VIC_EXC_TICK] = 1'b1;
      end
      // Set wins over clear; one bit per source collapses repeats
      nxt_pend = (pend_ff & ~pend_clr) | pend_set;
      nxt_active = (active_ff & ~ret_mask) | entry_onehot;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pend_ff <= `VIC_RST_EXC;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         active_ff <= `VIC_RST_EXC;
      end else begin
         active_ff <= nxt_active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Priority resolution

   always_comb begin
      candidates = pend_ff;
      candidates[31:16] = pend_ff[31:16] & enable_ff;
      win_num = `VIC_EXC_NONE;
      win_pri = `VIC_EFF_NONE;
      inner_num = `VIC_EXC_NONE;
      run_pri = `VIC_EFF_NONE;
      inner_any = 1'b0;
      // Ascending scan with strict compare keeps lowest number on ties
      for (int n = 0; n < 32; n++) begin
         if (candidates[n] && eff_pri(5'(n), irq_pri_ff, sys_pri_ff) < win_pri) begin
            win_pri = eff_pri(5'(n), irq_pri_ff, sys_pri_ff);
            win_num = 5'(n);
         end
         // Innermost handler is always the highest priority active one
         if (active_ff[n] && eff_pri(5'(n), irq_pri_ff, sys_pri_ff) < run_pri) begin
            run_pri = eff_pri(5'(n), irq_pri_ff, sys_pri_ff);
            inner_num = 5'(n);
            inner_any = 1'b1;
         end
      end
      // Strictly higher priority needed to preempt
      req_now = (win_pri < run_pri) && (state_ff == vic_pkg::RUN);
   end

   ////////////////////////////////////////////////////////////////////
   // Boot sequencer: stack pointer word, then reset vector

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         vic_pkg::BOOT_SP: begin
            if (i_boot_ack) begin
               nxt_state = vic_pkg::BOOT_RST;
            end
         end
         vic_pkg::BOOT_RST: begin
            if (i_boot_ack) begin
               nxt_state = vic_pkg::RUN;
            end
         end
         vic_pkg::RUN: begin
            nxt_state = vic_pkg::RUN;
         end
         default: begin
            nxt_state = vic_pkg::BOOT_SP;
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= vic_pkg::BOOT_SP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Boot always uses flash so the RAM reset slot is dead
   assign base_addr = (table_in_ram_select_ff && nxt_state == vic_pkg::RUN)
                      ? `VIC_BASE_RAM : `VIC_BASE_FLASH;

   ////////////////////////////////////////////////////////////////////
   // Core-facing outputs

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req     <= 1'b0;
         o_exc_num     <= `VIC_EXC_NONE;
         o_vector_addr <= `VIC_ADDR_SP;
         o_sp_load     <= 1'b1;
         o_booting     <= 1'b1;
      end else begin
         o_sp_load <= (nxt_state == vic_pkg::BOOT_SP);
         o_booting <= (nxt_state != vic_pkg::RUN);
         unique case (nxt_state)
            vic_pkg::BOOT_SP: begin
               o_irq_req     <= 1'b0;
               o_exc_num     <= `VIC_EXC_NONE;
               o_vector_addr <= `VIC_ADDR_SP;
            end
            vic_pkg::BOOT_RST: begin
               o_irq_req     <= 1'b0;
               o_exc_num     <= `VIC_EXC_RESET;
               o_vector_addr <= `VIC_ADDR_RESET;
            end
            default: begin
               // Number follows req_now; an entry cycle drops only the request
               o_irq_req     <= req_now && !i_exc_entry;
               o_exc_num     <= req_now ? win_num : `VIC_EXC_NONE;
               o_vector_addr <= base_addr + {25'h0, win_num, 2'b00};
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Memory read redirect to boot ROM

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_rd      <= 1'b0;
         o_mem_rom_sel <= 1'b0;
         o_mem_addr    <= `VIC_ADDR_SP;
      end else begin
         o_mem_rd      <= i_mem_rd;
         o_mem_addr    <= i_mem_addr;
         o_mem_rom_sel <= i_mem_rd && rom_redirect(i_mem_addr, reset_override_disable_ff,
                                                   system_request_bit_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register read

   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (i_reg_addr)
         `VIC_OFS_CONFIG:  rd_value[`VIC_CFG_RAM_BIT] = table_in_ram_select_ff;
         `VIC_OFS_SYSTEM_REQUEST_BIT: begin
            rd_value[`VIC_SYSTEM_REQUEST_BIT_BIT] = system_request_bit_ff;
            rd_value[`VIC_NO_OVR_BIT] = reset_override_disable_ff;
         end
         `VIC_OFS_ENABLE:  rd_value[15:0] = enable_ff;
         `VIC_OFS_IRQ_PRI: rd_value = irq_pri_ff;
         `VIC_OFS_SYS_PRI: rd_value[5:0] = sys_pri_ff;
         `VIC_OFS_PENDING: rd_value = pend_ff;
         `VIC_OFS_ACTIVE:  rd_value = active_ff;
         `VIC_OFS_VECTOR:  rd_value = o_vector_addr;
         default:          rd_value = 32'h0000_0000;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h0000_0000;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_value : 32'h0000_0000;
      end
   end

endmodule : vectored_interrupt_controller

`default_nettype wire

//--- verif/vic_asserts.sv
// Checker on the top ports of the interrupt controller.
// Assumes the bind below and one clock with async high reset.
`timescale 1ns/1ps
`default_nettype none
module vic_asserts (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        i_exc_entry,
   input wire logic        i_nmi_req,
   input wire logic        o_irq_req,
   input wire logic [4:0]  o_exc_num,
   input wire logic [31:0] o_vector_addr,
   input wire logic        o_sp_load,
   input wire logic        o_booting,
   input wire logic        i_mem_rd,
   input wire logic [31:0] i_mem_addr,
   input wire logic        o_mem_rd,
   input wire logic        o_mem_rom_sel,
   input wire logic [31:0] o_mem_addr
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_vector_addr: assert property (o_irq_req |-> o_vector_addr[6:0] == {o_exc_num, 2'b00}
      && o_vector_addr[31:7] inside {25'h0, 25'h0400000})
      else $error("vector address mismatch");
   a_boot_sp: assert property (o_sp_load |-> o_vector_addr == 32'h0 && o_booting)
      else $error("stack pointer word misplaced");
   a_boot_quiet: assert property (o_booting |-> !o_irq_req)
      else $error("request during boot");
   a_exc_range: assert property (o_irq_req |-> o_exc_num inside {2, 3, 11, 14, 15, [16:31]})
      else $error("reserved exception number");
   a_entry_drop: assert property (o_irq_req && i_exc_entry |=> !o_irq_req)
      else $error("request held after entry");
   a_req_stands: assert property (o_irq_req && !i_exc_entry |=> o_irq_req)
      else $error("request dropped without entry");
   a_nmi_fast: assert property (i_nmi_req |-> ##[1:3] (o_irq_req && o_exc_num == 5'h02))
      else $error("non-maskable request not forwarded");
   a_mem_copy: assert property (i_mem_rd |=> o_mem_rd && o_mem_addr == $past(i_mem_addr))
      else $error("memory read not passed on");
   a_mem_exact: assert property (i_mem_rd && i_mem_addr > 32'h8 |=> !o_mem_rom_sel)
      else $error("boot rom selected off its addresses");
   c_nmi: cover property (i_exc_entry && o_exc_num == 5'h02);
   c_ram: cover property (o_irq_req && o_vector_addr[29]);
   c_rom: cover property (i_mem_rd ##1 o_mem_rom_sel);
endmodule : vic_asserts
bind vectored_interrupt_controller vic_asserts u_chk (.*);
`default_nettype wire

//--- verif/core_model.sv
// Processor core stand-in: boot acks, handler entry and return.
// Assumes the controller's handshake outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module core_model #(parameter int HOLD = 20) (
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_irq_req,
   input  wire logic [4:0] i_exc_num,
   input  wire logic       i_booting,
   output logic            o_boot_ack,
   output logic            o_exc_entry,
   output logic [4:0]      o_entry_num,
   output logic            o_exc_return
);
   int depth;
   int cnt;
   // Nesting depth; entry and return never share a cycle
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_boot_ack <= 1'b0;
         o_exc_entry <= 1'b0;
         o_entry_num <= 5'h00;
         o_exc_return <= 1'b0;
         depth <= 0;
         cnt <= 0;
      end else begin
         o_boot_ack <= i_booting && !o_boot_ack;
         o_exc_entry <= i_irq_req && !o_exc_entry && !o_exc_return;
         o_entry_num <= i_exc_num;
         o_exc_return <= depth > 0 && cnt >= HOLD && !i_irq_req
            && !o_exc_return && !o_exc_entry;
         if (o_exc_entry) begin
            depth <= depth + 1;
            cnt <= 0;
         end else if (o_exc_return) begin
            depth <= depth - 1;
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : core_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes core_model answers the core handshake.
`include "vic_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        i_mclk = 1'b0;
   logic        i_rst = 1'b1;
   logic [7:0]  a = 8'h00;
   logic [31:0] wd = 32'h0, maddr = 32'h0, rdv, rdata, vec, omaddr;
   logic        wr = 1'b0, rd = 1'b0, nmi = 1'b0, hf = 1'b0, svc = 1'b0, mrd = 1'b0;
   logic [15:0] irq = 16'h0;
   logic        tick = 1'b0;
   logic        ack, ent, ret, req, spl, boot, omrd, rsel;
   logic [4:0]  ent_num, num;
   int          num_errors = 0, checks = 0, n, k;
   vic_pkg::exc_num_t seq[$];
   logic [7:0]  offs[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hFC};
   logic [4:0]  order[5] = '{5'h02, 5'h03, 5'h0F, 5'h1B, 5'h0B};
   always #2.5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (ent === 1'b1) seq.push_back(ent_num);
   vectored_interrupt_controller u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_reg_addr(a), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_irq(irq), .i_nmi_req(nmi), .i_hard_fault(hf), .i_svc_req(svc), .i_tick_req(tick),
      .i_boot_ack(ack), .i_exc_entry(ent), .i_entry_num(ent_num), .i_exc_return(ret),
      .o_irq_req(req), .o_exc_num(num), .o_vector_addr(vec), .o_sp_load(spl),
      .o_booting(boot), .i_mem_rd(mrd), .i_mem_addr(maddr), .o_mem_rd(omrd),
      .o_mem_rom_sel(rsel), .o_mem_addr(omaddr));
   core_model u_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_irq_req(req), .i_exc_num(num),
      .i_booting(boot), .o_boot_ack(ack), .o_exc_entry(ent), .o_entry_num(ent_num),
      .o_exc_return(ret));
   ////////////////////////////////////////////////////////////////
   task finish_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task lim(input int c, input int l);
      if (c >= l) begin
         num_errors++;
         finish_test();
      end
   endtask : lim
   task wr_reg(input logic [7:0] ad, input logic [31:0] d);
      @(posedge i_mclk);
      a <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] ad, output logic [31:0] d);
      @(posedge i_mclk);
      a <= ad;
      rd <= 1'b1;
      @(posedge i_mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task pulse(input logic [15:0] m);
      @(posedge i_mclk);
      irq <= m;
      repeat (2) @(posedge i_mclk);
      irq <= 16'h0;
   endtask : pulse
   task wait_req(input logic [4:0] en, input logic [31:0] ev);
      for (n = 0; n < 40 && req !== 1'b1; n++) @(posedge i_mclk) #1;
      lim(n, 40);
      chk(num, en);
      chk(vec, ev);
   endtask : wait_req
   task idle;
      k = 0;
      for (n = 0; n < 400 && k < 4; n++) begin
         @(posedge i_mclk) #1;
         k = (u_core.depth == 0 && req !== 1'b1) ? k + 1 : 0;
      end
      lim(n, 400);
   endtask : idle
   task do_reset;
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (16) @(posedge i_mclk);
      #1 chk(spl, 1'b1);
      chk(vec, 32'h0);
      @(posedge i_mclk);
      i_rst <= 1'b0;
      for (n = 0; n < 20 && spl !== 1'b0; n++) @(posedge i_mclk) #1;
      lim(n, 20);
      chk(vec, `VIC_ADDR_RESET);
      for (n = 0; n < 20 && boot !== 1'b0; n++) @(posedge i_mclk) #1;
      lim(n, 20);
   endtask : do_reset
   task mem_rd(input logic [31:0] ad, input logic exp);
      @(posedge i_mclk);
      mrd <= 1'b1;
      maddr <= ad;
      @(posedge i_mclk);
      mrd <= 1'b0;
      #1 chk(rsel, exp);
   endtask : mem_rd
   ////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      wr_reg(`VIC_OFS_PENDING, 32'hFFFF_FFFF);
      wr_reg(8'hFC, 32'hFFFF_FFFF);
      foreach (offs[i]) begin
         rd_reg(offs[i], rdv);
         chk(rdv, 32'h0);
      end
      $display("test reset done");
      wr_reg(`VIC_OFS_ENABLE, 32'h0000_FFFF);
      for (int j = 0; j < 16; j++) begin
         pulse(16'h0001 << j);
         wait_req(5'(16 + j), 32'(32'h40 + 4 * j));
         idle();
      end
      rd_reg(`VIC_OFS_PENDING, rdv);
      chk(rdv, 32'h0);
      wr_reg(`VIC_OFS_CONFIG, 32'h1);
      pulse(16'h0001);
      wait_req(5'h10, 32'h2000_0040);
      idle();
      do_reset();
      rd_reg(`VIC_OFS_CONFIG, rdv);
      chk(rdv, 32'h0);
      $display("test lines and table done");
      wr_reg(`VIC_OFS_ENABLE, 32'h0000_FFFF);
      pulse(16'h0280);
      wait_req(5'h17, 32'h5C);
      idle();
      wr_reg(`VIC_OFS_IRQ_PRI, 32'hFFFF_F3FF);
      pulse(16'h0024);
      wait_req(5'h15, 32'h54);
      idle();
      wr_reg(`VIC_OFS_IRQ_PRI, 32'h0000_000C);
      pulse(16'h0002);
      wait_req(5'h11, 32'h44);
      repeat (4) @(posedge i_mclk);
      pulse(16'h0040);
      wait_req(5'h16, 32'h58);
      chk(u_core.depth, 32'h1);
      idle();
      $display("test priority done");
      wr_reg(`VIC_OFS_ENABLE, 32'h0000_FFEF);
      pulse(16'h0010);
      repeat (8) @(posedge i_mclk);
      chk(req, 1'b0);
      rd_reg(`VIC_OFS_PENDING, rdv);
      chk(rdv, 32'h0010_0000);
      wr_reg(`VIC_OFS_ENABLE, 32'h0000_FFFF);
      wait_req(5'h14, 32'h50);
      idle();
      seq.delete();
      pulse(16'h0100);
      wait_req(5'h18, 32'h60);
      repeat (3) pulse(16'h0100);
      idle();
      chk(seq.size(), 2);
      seq.delete();
      @(posedge i_mclk);
      irq <= 16'h0400;
      for (n = 0; n < 300 && seq.size() < 2; n++) @(posedge i_mclk);
      lim(n, 300);
      irq <= 16'h0;
      idle();
      chk(seq[1], 5'h1A);
      $display("test pending done");
      wr_reg(`VIC_OFS_SYS_PRI, 32'h1);
      wr_reg(`VIC_OFS_ENABLE, 32'h0);
      pulse(16'h0800);
      repeat (6) @(posedge i_mclk);
      seq.delete();
      nmi <= 1'b1;
      hf <= 1'b1;
      svc <= 1'b1;
      tick <= 1'b1;
      @(posedge i_mclk);
      // Timer ties with line 11 at level 0, lower number goes first
      {nmi, hf, svc, tick} <= 4'b0000;
      wr_reg(`VIC_OFS_ENABLE, 32'h0000_FFFF);
      idle();
      foreach (order[i]) chk(seq[i], order[i]);
      for (int c = 0; c < 4; c++) begin
         wr_reg(`VIC_OFS_SYSTEM_REQUEST_BIT, 32'(c));
         for (int j = 0; j < 4; j++) begin
            mem_rd(32'(4 * j), (j < 2 && c < 2) || (j == 2 && c % 2 == 1));
         end
      end
      wr_reg(`VIC_OFS_SYSTEM_REQUEST_BIT, 32'h0);
      idle();
      $display("test exceptions and redirect done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
